// File: bench/tb_utp_test_regs.sv
// Purpose: self-checking bench of the test register block
// Assumes: fixed seed, random far-side stalls
// Notes:   expectations come from bench counts, never from the design
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb_utp_test_regs;
    localparam logic [15:0] TXL = utp_pkg::OFS_TX_AMOUNT_LOW;
    localparam logic [15:0] CMD = utp_pkg::OFS_TEST_COMMAND;
    localparam logic [15:0] RST = utp_pkg::OFS_TEST_RESET;
    localparam logic [15:0] RXL = utp_pkg::OFS_RX_AMOUNT_LOW;
    logic                           clock, tx_fifo_full, tx_fifo_write, rx_fifo_empty, rx_fifo_read;
    logic                           tx_bad, reg_rd_valid;
    logic                           rstn = 0, irq = 0, link = 0, stall = 0, restart = 1, load = 0, corrupt = 0;
    logic [utp_pkg::DATA_WIDTH-1:0] tx_fifo_wdata, rx_fifo_rdata;
    logic [31:0]                    reg_rd_data, tx_count, rd_val;
    logic [10:0]                    level = 11'h0;
    logic [7:0]                     rx_n = 8'h0;
    logic [4:0]                     last_bytes = 5'h0;
    utp_pkg::utp_reg_req_type       req = '0;
    int                             n_mismatch = 0, total_checks = 0, cycles = 0, n;

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // hang guard and random far-side stalls
    always @(posedge clock) begin
        cycles++;
        stall <= ($urandom % 4) == 0;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    utp_test_regs u_dut (.clock, .rstn, .reg_req(req), .reg_rd_data, .reg_rd_valid, .tx_fifo_full, .tx_fifo_write,
        .tx_fifo_wdata, .rx_fifo_empty, .rx_fifo_read, .rx_fifo_rdata, .rx_last_word_bytes(last_bytes),
        .rx_fifo_level(level), .rx_timeout_irq(irq), .link_up(link));
    utp_core_model u_model (.clock, .tx_fifo_write, .tx_fifo_wdata, .tx_fifo_full, .rx_fifo_read, .rx_fifo_empty,
        .rx_fifo_rdata, .stall, .restart, .load, .rx_n, .corrupt, .tx_count, .tx_bad);

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clock);
        req <= '{wr_en: 1'b1, rd_req: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        req <= '0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clock);
        req <= '{wr_en: 1'b0, rd_req: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clock);
        req <= '0;
        #1;
        `CHK("read valid", 1'b1, reg_rd_valid)
        rd_val = reg_rd_data;
    endtask
    // read until the masked value matches, bounded
    task automatic poll(input logic [15:0] a, input logic [31:0] m, input logic [31:0] want);
        for (int i = 0; i < 400; i++) begin
            rd(a);
            if ((rd_val & m) == want) break;
        end
    endtask
    task automatic pulse_rx(input logic [7:0] k, input logic bad);
        @(posedge clock);
        rx_n    <= k;
        corrupt <= bad;
        load    <= 1'b1;
        @(posedge clock);
        load <= 1'b0;
    endtask
    // command write, then model indexes back to zero
    task automatic rx_start(input logic [31:0] c);
        wr(CMD, c);
        @(posedge clock);
        restart <= 1'b1;
        @(posedge clock);
        restart <= 1'b0;
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'h802ede0e));
        repeat (12) @(posedge clock);
        rstn       <= 1'b1;
        restart    <= 1'b0;
        last_bytes <= 5'($urandom);
        level      <= 11'($urandom);
        link       <= 1'b1;
        // ****
        // idle reads
        // ****
        rd(CMD);
        `CHK("command", 32'h0, rd_val)
        rd(utp_pkg::OFS_FIFO_STATUS);
        `CHK("status", {level, last_bytes}, rd_val[15:0])
        rd(RST);
        `CHK("reset reg", 32'h10000, rd_val)
        rd(16'h1020);
        `CHK("unmapped", 32'h0, rd_val)
        // ****
        // transmit run with stalls
        // ****
        n = 5 + $urandom % 40;
        wr(TXL, 32'(n));
        wr(utp_pkg::OFS_TX_AMOUNT_HIGH, 32'h0);
        wr(CMD, 32'h0);
        rd(CMD);
        `CHK("busy", 1'b1, rd_val[0])
        poll(CMD, 32'h1, 32'h0);
        `CHK("tx words", 32'(n), tx_count)
        `CHK("tx data", 1'b0, tx_bad)
        rd(TXL);
        `CHK("sent", 32'(n), rd_val)
        wr(CMD, 32'h1);
        rd(TXL);
        `CHK("sent cleared", 32'h0, rd_val)
        rd(CMD);
        `CHK("no start", 1'b0, rd_val[0])
        // ****
        // receive checking
        // ****
        rx_start(32'h3);
        n = 20 + $urandom % 60;
        pulse_rx(8'(n), 1'b0);
        poll(RXL, 32'hffffffff, 32'(n));
        `CHK("rx count", 32'(n), rd_val)
        rd(utp_pkg::OFS_RX_AMOUNT_HIGH);
        `CHK("rx high", 32'h0, rd_val)
        rd(CMD);
        `CHK("no fail", 1'b0, rd_val[1])
        pulse_rx(8'h1, 1'b1);
        poll(RXL, 32'hffffffff, 32'(n + 1));
        pulse_rx(8'h3, 1'b0);
        poll(RXL, 32'hffffffff, 32'(n + 4));
        rd(CMD);
        `CHK("fail", 1'b1, rd_val[1])
        wr(CMD, 32'h3);
        rd(RXL);
        `CHK("rx cleared", 32'h0, rd_val)
        rd(CMD);
        `CHK("fail cleared", 1'b0, rd_val[1])
        rx_start(32'h1);
        pulse_rx(8'h2, 1'b1);
        poll(RXL, 32'hffffffff, 32'h2);
        rd(CMD);
        `CHK("check off", 1'b0, rd_val[1])
        // ****
        // timeout latch and soft reset
        // ****
        @(posedge clock);
        irq <= 1'b1;
        @(posedge clock);
        irq <= 1'b0;
        rd(RST);
        `CHK("timeout", 1'b1, rd_val[8])
        wr(RST, 32'h100);
        rd(RST);
        `CHK("timeout clr", 1'b0, rd_val[8])
        wr(RST, 32'h1);
        rd(RST);
        `CHK("soft bit", 1'b0, rd_val[0])
        rd(RXL);
        `CHK("rx after soft", 32'h0, rd_val)
        give_verdict();
    end
endmodule

bind utp_test_regs utp_test_regs_assertions u_chk (.*);

// File: bench/utp_core_model.sv
// Purpose: behavioural model of the core transmit and receive fifos
// Assumes: flags and data share the block clock
// Notes:   receive data turns over every idle cycle so a stale word never matches
`timescale 1ns/1ps
module utp_core_model (
    // clock
    input  wire logic                           clock,
    // transmit fifo side
    input  wire logic                           tx_fifo_write,
    input  wire logic [utp_pkg::DATA_WIDTH-1:0] tx_fifo_wdata,
    output logic                                tx_fifo_full,
    // receive fifo side
    input  wire logic                           rx_fifo_read,
    output logic                                rx_fifo_empty,
    output logic [utp_pkg::DATA_WIDTH-1:0]      rx_fifo_rdata,
    // bench controls
    input  wire logic                           stall,    // far side busy this cycle
    input  wire logic                           restart,  // both pattern indexes to zero
    input  wire logic                           load,     // make rx_n words available
    input  wire logic [7:0]                     rx_n,
    input  wire logic                           corrupt,  // flip bit 0 of words handed out
    output logic [31:0]                         tx_count, // words accepted
    output logic                                tx_bad    // wrong word or write while full
);
    logic [31:0] rx_idx;   // next receive pattern index
    logic [7:0]  rx_avail; // words waiting
    // incrementing lanes, lane 0 in the low bits
    function automatic logic [utp_pkg::DATA_WIDTH-1:0] patt(input logic [31:0] n);
        for (int i = 0; i < 8; i++) begin
            patt[i*32 +: 32] = {n[28:0], 3'(i)};
        end
    endfunction
    assign tx_fifo_full  = stall;
    assign rx_fifo_empty = (rx_avail == 8'h0) || stall;
    // check transmit words against the pattern
    always_ff @(posedge clock) begin
        if (restart) begin
            tx_count <= 32'h0;
            tx_bad   <= 1'b0;
        end else if (tx_fifo_write) begin
            tx_count <= tx_count + 32'h1;
            if (tx_fifo_full || tx_fifo_wdata !== patt(tx_count)) begin
                tx_bad <= 1'b1;
            end
        end
    end
    // data stands only in the cycle after the strobe, then turns over
    always_ff @(posedge clock) begin
        if (restart) begin
            rx_idx        <= 32'h0;
            rx_avail      <= 8'h0;
            rx_fifo_rdata <= '0;
        end else if (rx_fifo_read && !rx_fifo_empty) begin
            rx_avail      <= rx_avail - 8'h1;
            rx_idx        <= rx_idx + 32'h1;
            rx_fifo_rdata <= patt(rx_idx) ^ 256'(corrupt);
        end else begin
            rx_fifo_rdata <= ~rx_fifo_rdata;
            if (load) begin
                rx_avail <= rx_n;
            end
        end
    end
endmodule

// File: bench/utp_test_regs_assertions.sv
// Purpose: port checks of the test register block
// Assumes: one clock, synchronous active-low reset, one-cycle read answer
// Notes:   attached by bind from the bench top file
`timescale 1ns/1ps
module utp_test_regs_assertions (
    // clock and reset
    input wire logic                     clock,
    input wire logic                     rstn,
    // register access
    input wire utp_pkg::utp_reg_req_type reg_req,
    input wire logic [31:0]              reg_rd_data,
    input wire logic                     reg_rd_valid,
    // core fifos and status
    input wire logic                     tx_fifo_full,
    input wire logic                     tx_fifo_write,
    input wire logic                     rx_fifo_empty,
    input wire logic                     rx_fifo_read,
    input wire logic [4:0]               rx_last_word_bytes,
    input wire logic [10:0]              rx_fifo_level,
    input wire logic                     rx_timeout_irq,
    input wire logic                     link_up
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // ****
    // register access steps
    // ****
    sequence rd_at(logic [15:0] a);
        reg_req.rd_req && reg_req.addr == a;
    endsequence
    sequence cmd_write;
        reg_req.wr_en && reg_req.addr == utp_pkg::OFS_TEST_COMMAND;
    endsequence

    // ****
    // checks
    // ****
    a_rx_read_empty: assert property (rx_fifo_read == !rx_fifo_empty)
        else $error("read strobe not inverse of empty");
    a_tx_full_hold: assert property (tx_fifo_full |-> !tx_fifo_write)
        else $error("transmit write while full");
    a_rd_valid_lat: assert property (reg_req.rd_req |=> reg_rd_valid)
        else $error("read answer missing");
    a_valid_only_read: assert property (!reg_req.rd_req |=> !reg_rd_valid)
        else $error("stray read answer");
    a_rd_data_hold: assert property (!reg_req.rd_req |=> $stable(reg_rd_data))
        else $error("read data moved");
    a_status_map: assert property (rd_at(utp_pkg::OFS_FIFO_STATUS) |=>
        reg_rd_data == {7'h0, $past(tx_fifo_full), 8'h0, $past(rx_fifo_level), $past(rx_last_word_bytes)})
        else $error("fifo status word wrong");
    a_link_soft_read: assert property (rd_at(utp_pkg::OFS_TEST_RESET) |=>
        reg_rd_data[16] == $past(link_up) && !reg_rd_data[0])
        else $error("reset register read wrong");
    a_timeout_seen: assert property (rx_timeout_irq ##1 !reg_req.wr_en ##1
        rd_at(utp_pkg::OFS_TEST_RESET) |=> reg_rd_data[8])
        else $error("timeout latch not set");
    a_rx_count_clear: assert property (cmd_write ##2 rd_at(utp_pkg::OFS_RX_AMOUNT_LOW) |=>
        reg_rd_data <= 32'h3)
        else $error("received count not cleared");
endmodule

// File: rtl/utp_pkg.sv
// Purpose: shared constants, register map and carrier types of the test pattern block
// Assumes: one 100 MHz clock, 32-bit register words, 256-bit test data words
// Notes:   every offset below is a byte address; bits [1:0] of an access are ignored
package utp_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int DATA_WIDTH  = 256;   // test word width
    localparam int COUNT_WIDTH = 43;    // word counters, in 256-bit units
    localparam int HIGH_WIDTH  = 11;    // upper part of a 43-bit count
    localparam int ADDR_WIDTH  = 16;    // register byte address
    localparam int FIFO_DEPTH  = 32;    // staging buffer ahead of the core
    localparam int LANES       = DATA_WIDTH / 32;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [15:0] OFS_TX_AMOUNT_LOW  = 16'h1000;
    localparam logic [15:0] OFS_TX_AMOUNT_HIGH = 16'h1004;
    localparam logic [15:0] OFS_TEST_COMMAND   = 16'h1008;
    localparam logic [15:0] OFS_TEST_RESET     = 16'h100c;
    localparam logic [15:0] OFS_FIFO_STATUS    = 16'h1010;
    localparam logic [15:0] OFS_RX_AMOUNT_LOW  = 16'h1014;
    localparam logic [15:0] OFS_RX_AMOUNT_HIGH = 16'h1018;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CMD_START_BIT   = 0;   // write: 0 starts a transmit run
    localparam int CMD_CHECK_BIT   = 1;   // write: check enable
    localparam int CMD_BUSY_BIT    = 0;   // read: transmit busy
    localparam int CMD_FAIL_BIT    = 1;   // read: check failure
    localparam int RST_SOFT_BIT    = 0;   // write: soft reset
    localparam int RST_TIMEOUT_BIT = 8;   // write clears, read shows latch
    localparam int RST_LINK_BIT    = 16;  // read: link status
    localparam int FST_LAST_LSB    = 0;   // last-word byte count [4:0]
    localparam int FST_LEVEL_LSB   = 5;   // receive fifo level [15:5]
    localparam int FST_FULL_BIT    = 24;  // transmit fifo full

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 43'h0;
    localparam logic [31:0]            WORD_RESET  = 32'h0;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    // one register request from the bus side
    typedef struct packed {
        logic                  wr_en;    // write strobe
        logic                  rd_req;   // read request
        logic [ADDR_WIDTH-1:0] addr;     // byte address
        logic [31:0]           wdata;    // write data
    } utp_reg_req_type;

    // 32-bit incrementing pattern, eight lanes per word taken from the count
    function automatic logic [DATA_WIDTH-1:0] utp_pattern(input logic [COUNT_WIDTH-1:0] count);
        logic [DATA_WIDTH-1:0] word;
        word = '0;
        for (int i = 0; i < LANES; i++) begin
            word[i*32 +: 32] = {count[28:0], 3'(i)};
        end
        return word;
    endfunction

endpackage

// File: rtl/utp_test_regs.sv
// Purpose: test register block with transmit pattern source and receive pattern checker
// Assumes: core fifo flags and data share this clock; reads answer after one cycle
// Notes:   a 32-word staging fifo sits between the pattern source and the core
//
// Contract
// - command write with bit0 low starts transmit; a zero programmed total does not start
// - command bit1 enables receive word checking
// - command bit0 reads transmit busy
// - command bit1 reads error, cleared on any command write/reset; a mismatch in the write cycle still sets it
// - reset register bit0 soft-resets, self-clearing
// - reset register bit8 write clears timeout latch
// - reset register bit8 reads latched timeout interrupt
// - reset register bit16 reads link status
// - fifo status shows bytes, level, full
// - received count 43 bits over two registers
// - command write zeroes received count
// - start command sets transmit run flag; a zero programmed total clears it instead
// - one word per cycle, no write when full
// - sent count drives 32-bit incrementing data
// - run flag drops at programmed total
// - checking flags any mismatch as failure
// - receive read strobe is inverse of empty
// - data valid next cycle; delayed strobe counts
// - expected word derived from received count
// - total length written, reads give sent count
// - read data one cycle later with valid
// - test words are 256 bits wide
`timescale 1ns/1ps

// ****************************************************************
// staging fifo
// ****************************************************************
module utp_fifo #(
    parameter int WIDTH = 256,  // word width
    parameter int DEPTH = 32    // words held
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             flush,      // drop all content
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];   // storage
    logic [AW:0]      wr_ptr;        // extra bit tells full from empty
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    // honest flags straight from the pointers
    assign out_valid = (wr_ptr != rd_ptr);
    assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // storage needs no reset, only the pointers do
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // write pointer
    always_ff @(posedge clock) begin
        if (!rstn || flush) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    // read pointer
    always_ff @(posedge clock) begin
        if (!rstn || flush) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// ****************************************************************
// test register block
// ****************************************************************
module utp_test_regs (
    // clock and reset
    input  wire logic                                clock,
    input  wire logic                                rstn,
    // register access
    input  wire utp_pkg::utp_reg_req_type            reg_req,
    output logic [31:0]                              reg_rd_data,
    output logic                                     reg_rd_valid,
    // core transmit fifo
    input  wire logic                                tx_fifo_full,
    output logic                                     tx_fifo_write,
    output logic [utp_pkg::DATA_WIDTH-1:0]           tx_fifo_wdata,
    // core receive fifo
    input  wire logic                                rx_fifo_empty,
    output logic                                     rx_fifo_read,
    input  wire logic [utp_pkg::DATA_WIDTH-1:0]      rx_fifo_rdata,
    input  wire logic [4:0]                          rx_last_word_bytes,
    input  wire logic [10:0]                         rx_fifo_level,
    // core status
    input  wire logic                                rx_timeout_irq,
    input  wire logic                                link_up
);
    localparam int CW = utp_pkg::COUNT_WIDTH;
    localparam int HW = utp_pkg::HIGH_WIDTH;

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic          cmd_write;            // any write to the command register
    logic          start_cmd;            // command write that starts a run
    logic          rst_write;            // any write to the reset register
    logic          soft_reset;           // self-clearing soft reset
    logic          test_rstn;            // system or soft reset, active low
    logic [CW-1:0] tx_total_setting;     // programmed transmit length
    logic [CW-1:0] sent_word_count;      // words handed to the staging fifo
    logic [CW-1:0] received_word_count;  // words taken from the core
    logic          tx_run_flag;          // pattern source active
    logic          check_enable;         // compare received words
    logic          check_fail_flag;      // sticky mismatch
    logic          timeout_latch;        // sticky copy of the core timeout
    logic          rx_read_delayed;      // receive data valid this cycle
    logic          src_ready;            // staging fifo can take a word
    logic          stage_valid;          // staging fifo holds a word
    logic          push_word;            // pattern word accepted
    logic [utp_pkg::DATA_WIDTH-1:0] expected_word;
    logic [31:0]   next_rd_data;         // read mux output

    // ****************************************************************
    // write decode
    // ****************************************************************
    assign cmd_write = reg_req.wr_en && (reg_req.addr[15:2] == utp_pkg::OFS_TEST_COMMAND[15:2]);
    assign rst_write = reg_req.wr_en && (reg_req.addr[15:2] == utp_pkg::OFS_TEST_RESET[15:2]);
    // a cleared start bit starts a run, a set one leaves the run flag alone
    assign start_cmd = cmd_write && !reg_req.wdata[utp_pkg::CMD_START_BIT];
    assign test_rstn = rstn && !soft_reset;

    // soft reset pulse, high for exactly one cycle after the write
    always_ff @(posedge clock) begin
        if (!rstn) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= rst_write && reg_req.wdata[utp_pkg::RST_SOFT_BIT];
        end
    end

    // transmit length setting, only the system reset clears it
    always_ff @(posedge clock) begin
        if (!rstn) begin
            tx_total_setting <= utp_pkg::COUNT_RESET;
        end else if (reg_req.wr_en && reg_req.addr[15:2] == utp_pkg::OFS_TX_AMOUNT_LOW[15:2]) begin
            tx_total_setting[31:0] <= reg_req.wdata;
        end else if (reg_req.wr_en && reg_req.addr[15:2] == utp_pkg::OFS_TX_AMOUNT_HIGH[15:2]) begin
            tx_total_setting[CW-1:32] <= reg_req.wdata[HW-1:0];
        end
    end

    // check mode follows every command write
    always_ff @(posedge clock) begin
        if (!test_rstn) begin
            check_enable <= 1'b0;
        end else if (cmd_write) begin
            check_enable <= reg_req.wdata[utp_pkg::CMD_CHECK_BIT];
        end
    end

    // timeout latch: a new timeout wins over a clearing write in the same cycle,
    // and the soft reset leaves it alone so software can still read it
    always_ff @(posedge clock) begin
        if (!rstn) begin
            timeout_latch <= 1'b0;
        end else if (rx_timeout_irq) begin
            timeout_latch <= 1'b1;
        end else if (rst_write && reg_req.wdata[utp_pkg::RST_TIMEOUT_BIT]) begin
            timeout_latch <= 1'b0;
        end
    end

    // ****************************************************************
    // pattern source
    // ****************************************************************
    assign push_word = tx_run_flag && src_ready;

    // run flag; a zero length never starts, since it could never finish
    always_ff @(posedge clock) begin
        if (!test_rstn) begin
            tx_run_flag <= 1'b0;
        end else if (start_cmd) begin
            tx_run_flag <= (tx_total_setting != utp_pkg::COUNT_RESET);
        end else if (push_word && (sent_word_count + 1'b1 == tx_total_setting)) begin
            tx_run_flag <= 1'b0;
        end
    end

    // sent count, zeroed by a command write so the readback restarts
    always_ff @(posedge clock) begin
        if (!test_rstn) begin
            sent_word_count <= utp_pkg::COUNT_RESET;
        end else if (cmd_write) begin
            sent_word_count <= utp_pkg::COUNT_RESET;
        end else if (push_word) begin
            sent_word_count <= sent_word_count + 1'b1;
        end
    end

    // the staging fifo absorbs full bursts of the core; its own full
    // stalls the source, so nothing is lost when the core backs up
    utp_fifo #(
        .WIDTH (utp_pkg::DATA_WIDTH),
        .DEPTH (utp_pkg::FIFO_DEPTH)
    ) u_stage (
        .clock     (clock),
        .rstn      (rstn),
        .flush     (soft_reset),
        .in_valid  (tx_run_flag),
        .in_ready  (src_ready),
        .in_data   (utp_pkg::utp_pattern(sent_word_count)),
        .out_valid (stage_valid),
        .out_ready (!tx_fifo_full),
        .out_data  (tx_fifo_wdata)
    );

    // one word per cycle while held words exist and the core has room
    assign tx_fifo_write = stage_valid && !tx_fifo_full;

    // ****************************************************************
    // pattern checker
    // ****************************************************************
    assign rx_fifo_read  = !rx_fifo_empty;
    assign expected_word = utp_pkg::utp_pattern(received_word_count);

    // data arrives one cycle after the strobe
    always_ff @(posedge clock) begin
        if (!test_rstn) begin
            rx_read_delayed <= 1'b0;
        end else begin
            rx_read_delayed <= rx_fifo_read;
        end
    end

    // received count
    always_ff @(posedge clock) begin
        if (!test_rstn) begin
            received_word_count <= utp_pkg::COUNT_RESET;
        end else if (cmd_write) begin
            received_word_count <= utp_pkg::COUNT_RESET;
        end else if (rx_read_delayed) begin
            received_word_count <= received_word_count + 1'b1;
        end
    end

    // failure flag: a mismatch in the cycle of a command write still sets it
    always_ff @(posedge clock) begin
        if (!test_rstn) begin
            check_fail_flag <= 1'b0;
        end else if (rx_read_delayed && check_enable && (rx_fifo_rdata != expected_word)) begin
            check_fail_flag <= 1'b1;
        end else if (cmd_write) begin
            check_fail_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    // read mux; unmapped addresses answer zero
    always_comb begin
        next_rd_data = utp_pkg::WORD_RESET;
        if (reg_req.addr[15:2] == utp_pkg::OFS_TX_AMOUNT_LOW[15:2]) begin
            next_rd_data = sent_word_count[31:0];
        end else if (reg_req.addr[15:2] == utp_pkg::OFS_TX_AMOUNT_HIGH[15:2]) begin
            next_rd_data[HW-1:0] = sent_word_count[CW-1:32];
        end else if (reg_req.addr[15:2] == utp_pkg::OFS_TEST_COMMAND[15:2]) begin
            // busy covers words still waiting in the staging fifo
            next_rd_data[utp_pkg::CMD_BUSY_BIT] = tx_run_flag || stage_valid;
            next_rd_data[utp_pkg::CMD_FAIL_BIT] = check_fail_flag;
        end else if (reg_req.addr[15:2] == utp_pkg::OFS_TEST_RESET[15:2]) begin
            next_rd_data[utp_pkg::RST_TIMEOUT_BIT] = timeout_latch;
            next_rd_data[utp_pkg::RST_LINK_BIT]    = link_up;
        end else if (reg_req.addr[15:2] == utp_pkg::OFS_FIFO_STATUS[15:2]) begin
            next_rd_data[utp_pkg::FST_LAST_LSB +: 5]   = rx_last_word_bytes;
            next_rd_data[utp_pkg::FST_LEVEL_LSB +: 11] = rx_fifo_level;
            next_rd_data[utp_pkg::FST_FULL_BIT]        = tx_fifo_full;
        end else if (reg_req.addr[15:2] == utp_pkg::OFS_RX_AMOUNT_LOW[15:2]) begin
            next_rd_data = received_word_count[31:0];
        end else if (reg_req.addr[15:2] == utp_pkg::OFS_RX_AMOUNT_HIGH[15:2]) begin
            next_rd_data[HW-1:0] = received_word_count[CW-1:32];
        end
    end

    // registered answer, one cycle after the request
    always_ff @(posedge clock) begin
        if (!rstn) begin
            reg_rd_data  <= utp_pkg::WORD_RESET;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_req.rd_req;
            if (reg_req.rd_req) begin
                reg_rd_data <= next_rd_data;
            end
        end
    end
endmodule
